// ---- src/adsc_pkg.sv ----
// Constants, field layouts and shared types of the converter sequencer.
// Assumes a single 200 MHz system clock and a 32-bit Wishbone register bus.
package adsc_pkg;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int unsigned CLK_FREQ_MHZ  = 200;
   localparam int unsigned TAD_NS        = 1600;
   localparam int unsigned TAD_CYCLES    = (TAD_NS * CLK_FREQ_MHZ) / 1000;
   localparam int unsigned TAD_CNT_W     = 9;
   localparam logic [8:0]  TAD_LAST      = 9'(TAD_CYCLES - 1);
   localparam int unsigned CONV_TADS     = 11;
   localparam int unsigned ABORT_TADS    = 2;
   localparam logic [3:0]  SAR_LAST_STEP = 4'hA;
   localparam logic [1:0]  ABORT_LAST    = 2'(ABORT_TADS - 1);

   // ----------------------------------------------------------------------
   // Register map and fields
   // ----------------------------------------------------------------------
   localparam logic [3:0]  OFS_CTRL      = 4'h0;
   localparam logic [3:0]  OFS_RES_HI    = 4'h4;
   localparam logic [3:0]  OFS_RES_LO    = 4'h8;
   localparam logic [3:0]  OFS_STATUS    = 4'hC;
   localparam logic [7:0]  CTRL_RESET    = 8'h00;
   localparam logic [7:0]  CTRL_WMASK    = 8'hDF;
   localparam int unsigned DONE_BIT      = 0;
   localparam int unsigned RESULT_W      = 10;
   localparam logic [9:0]  RESULT_RESET  = 10'h000;
   localparam logic [9:0]  SAR_FIRST     = 10'h200;

   localparam logic [2:0]  CHAN_COMP_REF = 3'h4;
   localparam logic [2:0]  CHAN_REF_0V6  = 3'h5;
   localparam logic [2:0]  CHAN_REF_1V2  = 3'h6;
   localparam logic [2:0]  CHAN_RESERVED = 3'h7;

   typedef struct packed {
      logic       result_justify_select;
      logic       reference_source_select;
      logic       unused;
      logic [2:0] input_channel_select;
      logic       go;
      logic       converter_enable;
   } adsc_ctrl_t;

   typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_ABORT} adsc_state_t;

   // ----------------------------------------------------------------------
   // Result formatting
   // ----------------------------------------------------------------------
   function automatic logic [7:0] fmt_high(input logic [9:0] res, input logic right);
      fmt_high = right ? {6'h00, res[9:8]} : res[9:2];
   endfunction

   function automatic logic [7:0] fmt_low(input logic [9:0] res, input logic right);
      fmt_low = right ? res[7:0] : {res[1:0], 6'h00};
   endfunction

endpackage

// ---- src/adsc_tad_div.sv ----
// Conversion clock divider: one-cycle tick every conversion clock period.
// Assumes restart is a one-cycle pulse from the sequencer.
`timescale 1ns/100ps
module adsc_tad_div
(
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic restart,
   input  wire logic run,
   output logic      tick
);
   logic [adsc_pkg::TAD_CNT_W-1:0] cnt;
   logic [adsc_pkg::TAD_CNT_W-1:0] next_cnt;
   logic                           next_tick;

   always_comb
   begin
      next_cnt  = '0;
      next_tick = 1'b0;
      if (!restart && run)
      begin
         next_tick = (cnt == adsc_pkg::TAD_LAST);
         next_cnt  = next_tick ? '0 : cnt + 9'h001;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cnt  <= '0;
         tick <= 1'b0;
      end
      else
      begin
         cnt  <= next_cnt;
         tick <= next_tick;
      end
   end
endmodule

// ---- src/adsc_sar.sv ----
// Successive-approximation engine: one sample step, then ten bit decisions.
// Assumes cmp_high is the analog comparator, high when input exceeds trial.
`timescale 1ns/100ps
module adsc_sar
(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       tad_tick,
   input  wire logic       start,
   input  wire logic       abort,
   input  wire logic       cmp_high,
   output logic            busy,
   output logic            hold,
   output logic            done,
   output logic [9:0]      trial,
   output logic [9:0]      result
);
   logic [3:0] step;
   logic [3:0] next_step;
   logic       next_busy;
   logic       next_hold;
   logic       next_done;
   logic [9:0] next_trial;
   logic [9:0] next_result;

   always_comb
   begin
      logic [3:0] bi;
      logic [9:0] t;
      bi          = 4'hA - step;
      t           = trial;
      next_step   = step;
      next_busy   = busy;
      next_hold   = hold;
      next_done   = 1'b0;
      next_trial  = trial;
      next_result = result;
      if (abort)
      begin
         next_busy = 1'b0;
         next_hold = 1'b0;
         next_step = 4'h0;
      end
      else if (start)
      begin
         next_busy  = 1'b1;
         next_step  = 4'h0;
         next_trial = 10'h000;
      end
      else if (busy && tad_tick)
      begin
         next_step = step + 4'h1;
         if (step == 4'h0)
         begin
            next_hold  = 1'b1;
            next_trial = adsc_pkg::SAR_FIRST;
         end
         else
         begin
            if (!cmp_high)
               t[bi] = 1'b0;
            if (bi != 4'h0)
               t[bi - 4'h1] = 1'b1;
            next_trial = t;
            if (step == adsc_pkg::SAR_LAST_STEP)
            begin
               next_done   = 1'b1;
               next_result = t;
               next_busy   = 1'b0;
               next_hold   = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         step   <= 4'h0;
         busy   <= 1'b0;
         hold   <= 1'b0;
         done   <= 1'b0;
         trial  <= 10'h000;
         result <= 10'h000;
      end
      else
      begin
         step   <= next_step;
         busy   <= next_busy;
         hold   <= next_hold;
         done   <= next_done;
         trial  <= next_trial;
         result <= next_result;
      end
   end
endmodule

// ---- src/adsc_top.sv ----
// Converter sequencer: control and result registers behind a Wishbone slave.
// Assumes a classic Wishbone master and an external analog front end.
//
// Functional notes
// - control bit 7 set means right justification
// - bit 6 picks external reference or supply
// - bits 4-2 select one of seven inputs
// - writing go starts conversion, reads one meanwhile
// - hardware clears go when conversion ends
// - bit 0 enables converter, zero powers down
// - left format: high byte holds bits 9-2
// - left format: low byte bits 1-0, rest zero
// - right format: high byte bits 9-8 only
// - right format: low byte holds bits 7-0
// - completion clears go, sets flag, loads result
// - clearing go aborts, keeps result, 2-period wait
// - full conversion takes eleven conversion periods
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module adsc_top
(
   input  wire logic        CLOCK,
   input  wire logic        SRST,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [3:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   input  wire logic        COMPARATOR_HIGH,
   output logic             CONVERTER_ENABLE,
   output logic             REFERENCE_SOURCE_SELECT,
   output logic      [2:0]  INPUT_CHANNEL_SELECT,
   output logic             SAMPLE_ACQUIRE,
   output logic             SAMPLE_HOLD,
   output logic      [9:0]  TRIAL_CODE,
   output logic             CONVERSION_DONE_FLAG
);
   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   adsc_pkg::adsc_ctrl_t  ctrl;
   adsc_pkg::adsc_ctrl_t  next_ctrl;
   adsc_pkg::adsc_state_t state;
   adsc_pkg::adsc_state_t next_state;
   logic [1:0]            abort_cnt;
   logic [1:0]            next_abort_cnt;
   logic [9:0]            result;
   logic [9:0]            next_result;
   logic                  done_flag;
   logic                  next_done_flag;
   logic                  next_ack;
   logic [31:0]           next_dat;
   logic                  next_acquire;
   logic                  sar_start;
   logic                  sar_abort;
   logic                  div_restart;
   logic                  tad_tick;
   logic                  sar_busy;
   logic                  sar_done;
   logic [9:0]            sar_result;
   logic                  req;
   logic                  wr;
   logic                  rd;

   assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   assign wr  = req && WB_WE_I && WB_SEL_I[0];
   assign rd  = req && !WB_WE_I;

   // ----------------------------------------------------------------------
   // Conversion clock and engine
   // ----------------------------------------------------------------------
   adsc_tad_div u_div
   (
      .clk     (CLOCK),
      .srst    (SRST),
      .restart (div_restart),
      .run     (sar_busy || state == adsc_pkg::ST_ABORT),
      .tick    (tad_tick)
   );

   adsc_sar u_sar
   (
      .clk      (CLOCK),
      .srst     (SRST),
      .tad_tick (tad_tick),
      .start    (sar_start),
      .abort    (sar_abort),
      .cmp_high (COMPARATOR_HIGH),
      .busy     (sar_busy),
      .hold     (SAMPLE_HOLD),
      .done     (sar_done),
      .trial    (TRIAL_CODE),
      .result   (sar_result)
   );

   // ----------------------------------------------------------------------
   // Register file and sequencing
   // ----------------------------------------------------------------------
   always_comb
   begin
      adsc_pkg::adsc_ctrl_t w;
      w              = adsc_pkg::adsc_ctrl_t'(WB_DAT_I[7:0] & adsc_pkg::CTRL_WMASK);
      next_ctrl      = ctrl;
      next_state     = state;
      next_abort_cnt = abort_cnt;
      next_result    = result;
      next_done_flag = done_flag;
      next_ack       = req;
      next_dat       = 32'h0000_0000;
      sar_start      = 1'b0;
      sar_abort      = 1'b0;
      div_restart    = 1'b0;

      if (wr && WB_ADR_I == adsc_pkg::OFS_CTRL)
      begin
         next_ctrl    = w;
         next_ctrl.go = 1'b0;
         if (state == adsc_pkg::ST_CONV)
         begin
            if (w.go && w.converter_enable)
               next_ctrl.go = 1'b1;
            else
            begin
               sar_abort      = 1'b1;
               div_restart    = 1'b1;
               next_abort_cnt = 2'h0;
               next_state     = adsc_pkg::ST_ABORT;
            end
         end
         else if (state == adsc_pkg::ST_IDLE && w.go && w.converter_enable
                  && ctrl.converter_enable)
         begin
            next_ctrl.go = 1'b1;
            sar_start    = 1'b1;
            div_restart  = 1'b1;
            next_state   = adsc_pkg::ST_CONV;
         end
      end
      else if (wr && WB_ADR_I == adsc_pkg::OFS_STATUS && WB_DAT_I[adsc_pkg::DONE_BIT])
         next_done_flag = 1'b0;

      if (state == adsc_pkg::ST_ABORT && tad_tick)
      begin
         next_abort_cnt = abort_cnt + 2'h1;
         if (abort_cnt == adsc_pkg::ABORT_LAST)
            next_state = adsc_pkg::ST_IDLE;
      end

      if (sar_done)
      begin
         next_ctrl.go   = 1'b0;
         next_result    = sar_result;
         next_done_flag = 1'b1;
         next_state     = adsc_pkg::ST_IDLE;
      end

      if (rd)
      begin
         if (WB_ADR_I == adsc_pkg::OFS_CTRL)
            next_dat = {24'h00_0000, ctrl & adsc_pkg::CTRL_WMASK};
         else if (WB_ADR_I == adsc_pkg::OFS_RES_HI)
            next_dat = {24'h00_0000,
                        adsc_pkg::fmt_high(result, ctrl.result_justify_select)};
         else if (WB_ADR_I == adsc_pkg::OFS_RES_LO)
            next_dat = {24'h00_0000,
                        adsc_pkg::fmt_low(result, ctrl.result_justify_select)};
         else if (WB_ADR_I == adsc_pkg::OFS_STATUS)
            next_dat = {31'h0000_0000, done_flag};
      end

      next_acquire = next_ctrl.converter_enable && next_state == adsc_pkg::ST_IDLE;
   end

   always_ff @(posedge CLOCK)
   begin
      if (SRST)
      begin
         ctrl           <= adsc_pkg::adsc_ctrl_t'(adsc_pkg::CTRL_RESET);
         state          <= adsc_pkg::ST_IDLE;
         abort_cnt      <= 2'h0;
         result         <= adsc_pkg::RESULT_RESET;
         done_flag      <= 1'b0;
         WB_ACK_O       <= 1'b0;
         WB_DAT_O       <= 32'h0000_0000;
         SAMPLE_ACQUIRE <= 1'b0;
      end
      else
      begin
         ctrl           <= next_ctrl;
         state          <= next_state;
         abort_cnt      <= next_abort_cnt;
         result         <= next_result;
         done_flag      <= next_done_flag;
         WB_ACK_O       <= next_ack;
         WB_DAT_O       <= next_dat;
         SAMPLE_ACQUIRE <= next_acquire;
      end
   end

   // Pin-facing control levels
   assign CONVERTER_ENABLE        = ctrl.converter_enable;
   assign REFERENCE_SOURCE_SELECT = ctrl.reference_source_select;
   assign INPUT_CHANNEL_SELECT    = ctrl.input_channel_select;
   assign CONVERSION_DONE_FLAG    = done_flag;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   localparam int ABT_MAX   = 2 * 320 + 2;
   localparam int CONV_BUSY = 11 * 320 + 1;

   logic [11:0] busy_cycles;
   always_ff @(posedge CLOCK)
   begin
      if (SRST || sar_start)
         busy_cycles <= 12'h000;
      else if (sar_busy)
         busy_cycles <= busy_cycles + 12'h001;
   end

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (SRST);

   sequence s_rd_hi;
      rd && WB_ADR_I == adsc_pkg::OFS_RES_HI;
   endsequence
   sequence s_rd_lo;
      rd && WB_ADR_I == adsc_pkg::OFS_RES_LO;
   endsequence
   sequence s_abort;
      wr && WB_ADR_I == adsc_pkg::OFS_CTRL && state == adsc_pkg::ST_CONV && !WB_DAT_I[1]
         && !sar_done;
   endsequence

   property p_left_high;
      s_rd_hi ##0 !ctrl.result_justify_select |=> WB_DAT_O[7:0] == $past(result[9:2]);
   endproperty
   a_left_high: assert property (p_left_high) else $error("left high byte wrong");

   property p_left_low;
      s_rd_lo ##0 !ctrl.result_justify_select
         |=> WB_DAT_O[7:0] == {$past(result[1:0]), 6'h00};
   endproperty
   a_left_low: assert property (p_left_low) else $error("left low byte wrong");

   property p_right_high;
      s_rd_hi ##0 ctrl.result_justify_select
         |=> WB_DAT_O[7:0] == {6'h00, $past(result[9:8])};
   endproperty
   a_right_high: assert property (p_right_high) else $error("right high byte wrong");

   property p_right_low;
      s_rd_lo ##0 ctrl.result_justify_select |=> WB_DAT_O[7:0] == $past(result[7:0]);
   endproperty
   a_right_low: assert property (p_right_low) else $error("right low byte wrong");

   property p_ref_chan;
      wr && WB_ADR_I == adsc_pkg::OFS_CTRL |=> REFERENCE_SOURCE_SELECT == $past(WB_DAT_I[6])
         && INPUT_CHANNEL_SELECT == $past(WB_DAT_I[4:2]) && WB_ACK_O;
   endproperty
   a_ref_chan: assert property (p_ref_chan) else $error("reference or channel not taken");

   property p_go_busy;
      sar_busy |-> ctrl.go && state == adsc_pkg::ST_CONV && ctrl.converter_enable;
   endproperty
   a_go_busy: assert property (p_go_busy) else $error("go low during conversion");

   property p_complete;
      sar_done |=> !ctrl.go && done_flag && result == $past(sar_result) && SAMPLE_ACQUIRE
         == ctrl.converter_enable;
   endproperty
   a_complete: assert property (p_complete) else $error("completion effects missing");

   property p_abort;
      s_abort |=> (state == adsc_pkg::ST_ABORT && !SAMPLE_ACQUIRE && $stable(result))
         ##[1:ABT_MAX] state == adsc_pkg::ST_IDLE;
   endproperty
   a_abort: assert property (p_abort) else $error("abort sequence wrong");

   property p_conv_len;
      sar_done |-> busy_cycles == 12'(CONV_BUSY);
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

   property p_bit5;
      rd && WB_ADR_I == adsc_pkg::OFS_CTRL |=> !WB_DAT_O[5];
   endproperty
   a_bit5: assert property (p_bit5) else $error("control bit 5 reads one");

endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the converter sequencer behind its Wishbone slave.
// Assumes the register map and timing of adsc_pkg; the bench models the comparator.
`timescale 1ns/100ps
module tb;
   logic        clock = 1'b0;
   logic        srst  = 1'b1;
   logic        cyc   = 1'b0;
   logic        stb   = 1'b0;
   logic        we    = 1'b0;
   logic [3:0]  adr   = 4'h0;
   logic [3:0]  sel   = 4'h0;
   logic [31:0] dat   = 32'h00000000;
   logic        cmp   = 1'b0;
   logic [31:0] dat_o;
   logic        ack;
   logic        enable;
   logic        ref_sel;
   logic [2:0]  chan;
   logic        acq;
   logic        hold;
   logic [9:0]  trial;
   logic        flag;
   logic [9:0]  analog   = 10'h000;
   logic [9:0]  last_res = 10'h000;
   int          cyc_cnt  = 0;
   int          n_mismatch  = 0;
   int          checks_done = 0;

   adsc_top dut
   (
      .CLOCK                   (clock),
      .SRST                    (srst),
      .WB_CYC_I                (cyc),
      .WB_STB_I                (stb),
      .WB_WE_I                 (we),
      .WB_ADR_I                (adr),
      .WB_SEL_I                (sel),
      .WB_DAT_I                (dat),
      .WB_DAT_O                (dat_o),
      .WB_ACK_O                (ack),
      .COMPARATOR_HIGH         (cmp),
      .CONVERTER_ENABLE        (enable),
      .REFERENCE_SOURCE_SELECT (ref_sel),
      .INPUT_CHANNEL_SELECT    (chan),
      .SAMPLE_ACQUIRE          (acq),
      .SAMPLE_HOLD             (hold),
      .TRIAL_CODE              (trial),
      .CONVERSION_DONE_FLAG    (flag)
   );

   // ----------------------------------------------------------------------
   // Clock, cycle counter and comparator model
   // ----------------------------------------------------------------------
   initial
   begin
      forever #2.5 clock = ~clock;
   end

   always @(posedge clock)
   begin
      cyc_cnt <= cyc_cnt + 1;
      cmp     <= (analog >= trial);
   end

   // ----------------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------------
   task automatic end_of_test;
      if (n_mismatch == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                      input logic [3:0] s, output logic [31:0] q);
      int n;
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= {24'h000000, d};
      sel <= s;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      if (ack !== 1'b1)
      begin
         n_mismatch++;
         end_of_test();
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, 4'h1, q);
   endtask

   task automatic rdchk(input logic [3:0] a, input logic [7:0] e, input string msg);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, 4'hF, q);
      chk(q, {24'h000000, e}, msg);
   endtask

   function automatic logic [7:0] hi_of(input logic [9:0] r, input logic right);
      return right ? {6'h00, r[9:8]} : r[9:2];
   endfunction

   function automatic logic [7:0] lo_of(input logic [9:0] r, input logic right);
      return right ? r[7:0] : {r[1:0], 6'h00};
   endfunction

   task automatic rd_result(input logic [9:0] r, input logic right);
      rdchk(adsc_pkg::OFS_RES_HI, hi_of(r, right), "result high");
      rdchk(adsc_pkg::OFS_RES_LO, lo_of(r, right), "result low");
   endtask

   // Waits on a level output; returns cycles waited, or ends the run on timeout
   task automatic wait_high(input int which, output int n);
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (((which == 0) ? flag : acq) !== 1'b1 && n < 5000);
      if (((which == 0) ? flag : acq) !== 1'b1)
      begin
         n_mismatch++;
         end_of_test();
      end
   endtask

   task automatic conv(input logic [9:0] a, input logic [7:0] cfg);
      logic [7:0] c;
      int         t0;
      int         n;
      c = (cfg & 8'hDD) | 8'h01;
      analog = a;
      wr(adsc_pkg::OFS_CTRL, c);
      chk({31'h0, acq}, 32'h1, "acquire when idle");
      chk({28'h0, ref_sel, chan}, {28'h0, c[6], c[4:2]}, "ref and channel");
      repeat (20) @(posedge clock);
      wr(adsc_pkg::OFS_CTRL, c | 8'h02);
      t0 = cyc_cnt;
      repeat (400) @(posedge clock);
      rdchk(adsc_pkg::OFS_CTRL, c | 8'h02, "go while converting");
      chk({31'h0, hold}, 32'h1, "hold while converting");
      wait_high(0, n);
      chk(32'((cyc_cnt - t0) inside {[3520:3524]}), 32'h1, "conversion length");
      rdchk(adsc_pkg::OFS_CTRL, c, "go cleared at end");
      rdchk(adsc_pkg::OFS_STATUS, 8'h01, "done flag set");
      rd_result(a, c[7]);
      wr(adsc_pkg::OFS_CTRL, c ^ 8'h80);
      rd_result(a, ~c[7]);
      wr(adsc_pkg::OFS_STATUS, 8'h01);
      rdchk(adsc_pkg::OFS_STATUS, 8'h00, "done flag cleared");
      last_res = a;
   endtask

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial
   begin
      int         n;
      int         t0;
      logic [7:0] d;
      logic [31:0] q;
      void'($urandom(32348));
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      repeat (2) @(posedge clock);
      rdchk(adsc_pkg::OFS_CTRL, 8'h00, "control reset");
      rd_result(10'h000, 1'b0);
      rdchk(adsc_pkg::OFS_STATUS, 8'h00, "status reset");
      // Every channel code; bit 5 and go without enable must not stick
      for (int ch = 0; ch < 8; ch++)
      begin
         d = {2'($urandom()), 1'b1, 3'(ch), 2'b10};
         wr(adsc_pkg::OFS_CTRL, d);
         rdchk(adsc_pkg::OFS_CTRL, d & 8'hDC, "control readback");
         chk({27'h0, enable, ref_sel, chan}, {27'h0, 1'b0, d[6], d[4:2]}, "pins");
      end
      // Go in the same write that enables is not taken
      wr(adsc_pkg::OFS_CTRL, 8'h03);
      rdchk(adsc_pkg::OFS_CTRL, 8'h01, "go with enable");
      // Corner and random conversions
      conv(10'h000, 8'h81);
      conv(10'h3FF, 8'h01);
      conv(10'h200, 8'hC9);
      conv(10'h1FF, 8'h11);
      repeat (2) conv(10'($urandom()), 8'($urandom()));
      // Result registers, unmapped place and disabled byte lane ignore writes
      wr(adsc_pkg::OFS_CTRL, 8'h01);
      wr(adsc_pkg::OFS_RES_HI, 8'hA5);
      wr(adsc_pkg::OFS_RES_LO, 8'h5A);
      wr(4'h2, 8'hFF);
      bus(1'b1, adsc_pkg::OFS_CTRL, 8'h45, 4'h0, q);
      rd_result(last_res, 1'b0);
      rdchk(4'h2, 8'h00, "unmapped read");
      rdchk(adsc_pkg::OFS_CTRL, 8'h01, "lane disabled");
      // Abort by clearing go: result kept, two-period wait, then acquire
      analog = ~last_res;
      wr(adsc_pkg::OFS_CTRL, 8'h03);
      repeat (800) @(posedge clock);
      wr(adsc_pkg::OFS_CTRL, 8'h01);
      t0 = cyc_cnt;
      chk({31'h0, acq}, 32'h0, "abort wait");
      wait_high(1, n);
      chk(32'((cyc_cnt - t0) inside {[636:646]}), 32'h1, "abort wait length");
      rdchk(adsc_pkg::OFS_CTRL, 8'h01, "go after abort");
      rdchk(adsc_pkg::OFS_STATUS, 8'h00, "no flag after abort");
      rd_result(last_res, 1'b0);
      // Disable during conversion powers down
      wr(adsc_pkg::OFS_CTRL, 8'h03);
      repeat (100) @(posedge clock);
      wr(adsc_pkg::OFS_CTRL, 8'h00);
      repeat (2) @(posedge clock);
      chk({30'h0, enable, acq}, 32'h0, "disabled");
      // Reset in mid conversion
      wr(adsc_pkg::OFS_CTRL, 8'h85);
      wait_high(1, n);
      wr(adsc_pkg::OFS_CTRL, 8'h87);
      repeat (50) @(posedge clock);
      rdchk(adsc_pkg::OFS_CTRL, 8'h87, "go before reset");
      srst <= 1'b1;
      repeat (3) @(posedge clock);
      srst <= 1'b0;
      repeat (2) @(posedge clock);
      chk({26'h0, enable, ref_sel, chan, hold}, 32'h0, "pins after reset");
      rdchk(adsc_pkg::OFS_CTRL, 8'h00, "control after reset");
      rd_result(10'h000, 1'b0);
      end_of_test();
   end
endmodule
